/* src/dmct_timers.sv */
`timescale 1ns/1ps
// Function
// [R1] mode 0 counts 13 bits: high byte plus low byte bits 4..0
// [R2] 13-bit wrap sets overflow flag; interrupt when enabled
// [R3] count select high counts falling edges of the count pin
// [R4] count pin levels last two clocks; event rate at most quarter clock
// [R5] internal clock: system clock if fast select, else prescaled clock
// [R6] count only with run set and gate open per polarity
// [R7] setting run never clears or reloads the count
// [R8] timer 1 mirrors timer 0 with its own bits and gate input 1
// [R9] mode 1 counts all 16 bits, same control and flagging
// [R10] mode 2: low byte counts, reloads from high byte on wrap
// [R11] mode 3: timer 0 low byte is an 8-bit counter on timer 0 bits
// [R12] mode 3: timer 0 high byte uses timer 1 run and flag
// [R13] timer 0 in mode 3: timer 1 internal only, no flag, still routed
// [R14] timer 0 in mode 3: timer 1 runs in modes 0-2, stops in 3
// [R15] overflow routing to serial, bus clock, timeout and counter array
// [R16] wide high overflow: full 16-bit or high byte when split
// [R17] converter start: timer 0, wide high when 16-bit, low when split
// [R18] wide timers hold 16-bit counts with 16-bit and split reload
// [R19] wide clock sources: system, div 12, comparator, osc div 8
// [R20] osc div 8 is synchronised; system clock must be fast enough
// [R21] 16-bit wide modes clock from the low half's clock
// [R22] overflow flag raises interrupt only with its enable set
// [R23] prescaled clock is system div 12, 4, 48 or ext div 8
// [R24] half clock select: 1 system clock, 0 alternate source
// [R25] pins pass a two-flop synchroniser before edges and gating
// [R26] flags stay set until cleared; set wins over clear
module dmct_timers
  import dmct_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              timer0_count_pin_in,
  input  wire logic              timer1_count_pin_in,
  input  wire logic              gate_input0_in,
  input  wire logic              gate_input1_in,
  input  wire logic              ext_osc_div8_in,
  input  wire logic              rtc_osc_div8_in,
  input  wire logic              cmp0_in,
  input  wire logic              cmp1_in,
  input  wire dmct_classic_cfg_t timer0_cfg_in,
  input  wire dmct_classic_cfg_t timer1_cfg_in,
  input  wire dmct_wide_cfg_t    timer_n_cfg_in [2],
  input  wire dmct_div_t         divider_choice_in,
  input  wire dmct_write_t       sw_write_in,
  input  wire logic [5:0]        flag_clear_in,
  output logic [7:0]             timer0_low_byte_out,
  output logic [7:0]             timer0_high_byte_out,
  output logic [7:0]             timer1_low_byte_out,
  output logic [7:0]             timer1_high_byte_out,
  output logic [1:0][7:0]        timer_n_low_byte_out,
  output logic [1:0][7:0]        timer_n_high_byte_out,
  output logic [5:0]             flags_out,
  output logic [3:0]             irq_out,
  output dmct_route_t            route_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input dmct_write_t w,
                                  input dmct_sel_t s);
    return w.en && (w.sel == s);
  endfunction

  // returns {overflow, high, low}; split_ok low holds the count
  function automatic logic [16:0] classic_step(input dmct_mode_t m,
                                               input logic [7:0] h,
                                               input logic [7:0] l,
                                               input logic split_ok);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] r;
    c13 = {h, l[4:0]} + 13'h0001;
    c16 = {h, l} + 16'h0001;
    r   = {1'b0, h, l};
    unique case (m)
      DMCT_MODE_13BIT:   r = {({h, l[4:0]} == DMCT_MAX13), c13[12:5],
                              l[7:5], c13[4:0]}; // R1 R2
      DMCT_MODE_16BIT:   r = {({h, l} == DMCT_MAX16), c16}; // R9
      DMCT_MODE_RELOAD8: r = {(l == DMCT_BYTE_MAX), h,
                              (l == DMCT_BYTE_MAX) ? h : l + 8'h01}; // R10
      DMCT_MODE_SPLIT8:  r = split_ok ? {(l == DMCT_BYTE_MAX), h,
                                         l + 8'h01} : r; // R11
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // pin synchroniser and edges
  // ---------------------------------------------------------------
  logic [DMCT_PIN_COUNT-1:0] pin_raw;
  logic [DMCT_PIN_COUNT-1:0] pin_meta;
  logic [DMCT_PIN_COUNT-1:0] pin_sync;
  logic [DMCT_PIN_COUNT-1:0] pin_prev;
  logic [DMCT_PIN_COUNT-1:0] pin_fall;
  logic [DMCT_PIN_COUNT-1:0] pin_rise;

  assign pin_raw = {cmp1_in, cmp0_in, rtc_osc_div8_in, ext_osc_div8_in,
                    gate_input1_in, gate_input0_in,
                    timer1_count_pin_in, timer0_count_pin_in};

  // only pin_sync and pin_prev feed logic; pin_meta may be metastable
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw; // R25 R20
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_fall = pin_prev & ~pin_sync; // R3
  assign pin_rise = ~pin_prev & pin_sync;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [3:0] div12_cnt;
  logic [1:0] div4_cnt;
  logic [1:0] div48_cnt;
  logic       tick12;
  logic       tick4;
  logic       tick48;
  logic       presc_tick;

  // div48 counts div12 ticks so the three rates stay phase aligned
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div12_cnt <= DMCT_DIV12_RST;
      div4_cnt  <= DMCT_DIV4_RST;
      div48_cnt <= DMCT_DIV4_RST;
    end else begin
      div12_cnt <= tick12 ? DMCT_DIV12_RST : div12_cnt + 4'h1;
      div4_cnt  <= div4_cnt + 2'h1;
      if (tick12) begin
        div48_cnt <= div48_cnt + 2'h1;
      end
    end
  end

  assign tick12 = (div12_cnt == DMCT_DIV12_LAST);
  assign tick4  = (div4_cnt == DMCT_DIV4_LAST);
  assign tick48 = tick12 && (div48_cnt == DMCT_DIV4_LAST);
  assign presc_tick = (divider_choice_in == DMCT_DIV12) ? tick12 :
                      (divider_choice_in == DMCT_DIV4)  ? tick4  :
                      (divider_choice_in == DMCT_DIV48) ? tick48 :
                      pin_rise[DMCT_PIN_EXT8]; // R23

  // ---------------------------------------------------------------
  // classic timers: clocking and run control
  // ---------------------------------------------------------------
  logic [7:0]  t0_low;
  logic [7:0]  t0_high;
  logic [7:0]  t1_low;
  logic [7:0]  t1_high;
  logic        t0_split;
  logic        int_tick0;
  logic        int_tick1;
  logic        run0;
  logic        run1;
  logic        step0;
  logic        step1;
  logic        step0_high;
  logic [16:0] next_t0;
  logic [16:0] next_t1;
  logic        ovf0;
  logic        ovf1;
  logic        ovf0_high;

  assign t0_split  = (timer0_cfg_in.mode == DMCT_MODE_SPLIT8);
  assign int_tick0 = timer0_cfg_in.fast_clock_select | presc_tick; // R5
  assign int_tick1 = timer1_cfg_in.fast_clock_select | presc_tick; // R8
  // open gate: input level differs from the polarity bit
  assign run0 = timer0_cfg_in.run &&
                (!timer0_cfg_in.gate_enable ||
                 (pin_sync[DMCT_PIN_TIMER0_GATE_ENABLE] !=
                  timer0_cfg_in.gate_polarity)); // R6
  // while timer 0 is split, timer 1 runs on its mode alone
  assign run1 = t0_split ? (timer1_cfg_in.mode != DMCT_MODE_SPLIT8) :
                (timer1_cfg_in.run &&
                 (!timer1_cfg_in.gate_enable ||
                  (pin_sync[DMCT_PIN_GATE1] !=
                   timer1_cfg_in.gate_polarity))); // R14 R8
  assign step0 = run0 && (timer0_cfg_in.count_select ?
                          pin_fall[DMCT_PIN_CNT0] : int_tick0); // R3
  assign step1 = run1 && ((timer1_cfg_in.count_select && !t0_split) ?
                          pin_fall[DMCT_PIN_CNT1] : int_tick1); // R13
  assign step0_high = t0_split && timer1_cfg_in.run && int_tick0; // R12

  assign next_t0 = classic_step(timer0_cfg_in.mode, t0_high, t0_low,
                                1'b1);
  assign next_t1 = classic_step(timer1_cfg_in.mode, t1_high, t1_low,
                                1'b0);
  assign ovf0      = step0 && next_t0[16];
  assign ovf1      = step1 && next_t1[16];
  assign ovf0_high = step0_high && (t0_high == DMCT_BYTE_MAX);

  // software loads win; counting resumes from the loaded value
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t0_low  <= DMCT_BYTE_RST;
      t0_high <= DMCT_BYTE_RST;
      t1_low  <= DMCT_BYTE_RST;
      t1_high <= DMCT_BYTE_RST;
    end else begin
      if (wr_hit(sw_write_in, DMCT_SEL_T0L)) begin
        t0_low <= sw_write_in.data;
      end else if (step0) begin
        t0_low <= next_t0[7:0]; // R7
      end
      if (wr_hit(sw_write_in, DMCT_SEL_T0H)) begin
        t0_high <= sw_write_in.data;
      end else if (step0_high) begin
        t0_high <= t0_high + 8'h01; // R12
      end else if (step0 && !t0_split) begin
        t0_high <= next_t0[15:8];
      end
      if (wr_hit(sw_write_in, DMCT_SEL_T1L)) begin
        t1_low <= sw_write_in.data;
      end else if (step1) begin
        t1_low <= next_t1[7:0];
      end
      if (wr_hit(sw_write_in, DMCT_SEL_T1H)) begin
        t1_high <= sw_write_in.data;
      end else if (step1) begin
        t1_high <= next_t1[15:8];
      end
    end
  end

  assign timer0_low_byte_out  = t0_low;
  assign timer0_high_byte_out = t0_high;
  assign timer1_low_byte_out  = t1_low;
  assign timer1_high_byte_out = t1_high;

  // ---------------------------------------------------------------
  // wide timers
  // ---------------------------------------------------------------
  logic [1:0] src_a;
  logic [1:0] src_b;
  logic [1:0] w_hi_ovf;
  logic [1:0] w_lo_ovf;
  logic [1:0] w_adc;

  assign src_a = {pin_rise[DMCT_PIN_EXT8], pin_rise[DMCT_PIN_RTC8]};
  assign src_b = {pin_rise[DMCT_PIN_CMP1], pin_rise[DMCT_PIN_CMP0]};

  for (genvar n = 0; n < 2; n++) begin : g_wide
    dmct_wide_cfg_t cfg;
    logic [7:0]  low;
    logic [7:0]  high;
    logic [7:0]  rl_low;
    logic [7:0]  rl_high;
    logic        alt_tick;
    logic        lo_tick;
    logic        hi_tick;
    logic        step16;
    logic        lo_step;
    logic        hi_step;
    logic        wrap16;
    logic        lo_wrap;
    logic        hi_wrap;
    logic [15:0] next_count;
    logic [7:0]  next_low;
    logic [7:0]  next_high;
    dmct_sel_t   sel_l;
    dmct_sel_t   sel_h;
    dmct_sel_t   sel_rl;
    dmct_sel_t   sel_rh;

    assign cfg    = timer_n_cfg_in[n];
    assign sel_l  = (n == 0) ? DMCT_SEL_T2L : DMCT_SEL_T3L;
    assign sel_h  = (n == 0) ? DMCT_SEL_T2H : DMCT_SEL_T3H;
    assign sel_rl = (n == 0) ? DMCT_SEL_T2RL : DMCT_SEL_T3RL;
    assign sel_rh = (n == 0) ? DMCT_SEL_T2RH : DMCT_SEL_T3RH;

    // clock tree of one wide timer
    assign alt_tick = (cfg.alt_clock_select == DMCT_ALT_SRC_A) ? src_a[n] :
                      (cfg.alt_clock_select == DMCT_ALT_SRC_B) ? src_b[n] :
                      tick12; // R19
    assign lo_tick = cfg.low_clock_select | alt_tick; // R24
    assign hi_tick = cfg.high_clock_select | alt_tick; // R24

    // whole count clocks from the low half's source when not split
    assign step16  = !cfg.split && cfg.run && lo_tick; // R21
    assign lo_step = cfg.split && lo_tick;
    assign hi_step = cfg.split && cfg.run && hi_tick;
    assign wrap16  = ({high, low} == DMCT_MAX16);
    assign lo_wrap = (low == DMCT_BYTE_MAX);
    assign hi_wrap = (high == DMCT_BYTE_MAX);
    assign next_count = wrap16 ? {rl_high, rl_low} :
                        {high, low} + 16'h0001; // R18
    assign next_low  = lo_wrap ? rl_low : low + 8'h01;
    assign next_high = hi_wrap ? rl_high : high + 8'h01;
    assign w_hi_ovf[n] = cfg.split ? (hi_step && hi_wrap) :
                         (step16 && wrap16); // R16
    assign w_lo_ovf[n] = cfg.split ? (lo_step && lo_wrap) :
                         (step16 && lo_wrap);
    assign w_adc[n] = cfg.split ? w_lo_ovf[n] : w_hi_ovf[n]; // R17

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        low     <= DMCT_BYTE_RST;
        high    <= DMCT_BYTE_RST;
        rl_low  <= DMCT_BYTE_RST;
        rl_high <= DMCT_BYTE_RST;
      end else begin
        if (wr_hit(sw_write_in, sel_rl)) begin
          rl_low <= sw_write_in.data;
        end
        if (wr_hit(sw_write_in, sel_rh)) begin
          rl_high <= sw_write_in.data;
        end
        if (wr_hit(sw_write_in, sel_l)) begin
          low <= sw_write_in.data;
        end else if (step16) begin
          low <= next_count[7:0];
        end else if (lo_step) begin
          low <= next_low;
        end
        if (wr_hit(sw_write_in, sel_h)) begin
          high <= sw_write_in.data;
        end else if (step16) begin
          high <= next_count[15:8];
        end else if (hi_step) begin
          high <= next_high;
        end
      end
    end

    assign timer_n_low_byte_out[n]  = low;
    assign timer_n_high_byte_out[n] = high;
  end

  // ---------------------------------------------------------------
  // flags, interrupts and routing
  // ---------------------------------------------------------------
  logic [5:0]  flag_set;
  logic [3:0]  next_irq;
  dmct_route_t next_route;

  // timer 1 sets its flag only while timer 0 is not split
  assign flag_set = {w_lo_ovf, w_hi_ovf,
                     t0_split ? ovf0_high : ovf1,
                     ovf0}; // R2 R12 R13
  assign next_irq = {timer_n_cfg_in[1].irq_enable &
                     flags_out[DMCT_FLAG_W_H+1],
                     timer_n_cfg_in[0].irq_enable &
                     flags_out[DMCT_FLAG_W_H],
                     timer1_cfg_in.irq_enable & flags_out[DMCT_FLAG_T1],
                     timer0_cfg_in.irq_enable &
                     flags_out[DMCT_FLAG_T0]}; // R22
  assign next_route.uart_baud     = ovf1; // R15 R13
  assign next_route.smbus_clk     = {w_lo_ovf[0], w_hi_ovf[0], ovf1, ovf0};
  assign next_route.smbus_timeout = w_hi_ovf[1];
  assign next_route.pca_clk       = ovf0;
  assign next_route.adc_start     = {w_adc[1], w_adc[0], ovf0}; // R17

  // a set in the clearing cycle wins so no overflow is lost
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_out <= '0;
      irq_out   <= '0;
      route_out <= '0;
    end else begin
      flags_out <= flag_set | (flags_out & ~flag_clear_in); // R26
      irq_out   <= next_irq;
      route_out <= next_route;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_mode0_wrap;
    step0 && !sw_write_in.en && timer0_cfg_in.mode == DMCT_MODE_13BIT &&
    {t0_high, t0_low[4:0]} == DMCT_MAX13
    |=> {t0_high, t0_low[4:0]} == 13'h0000 && flags_out[DMCT_FLAG_T0];
  endproperty
  a_mode0_wrap: assert property (p_mode0_wrap) // R1 R2
    else $error("13-bit wrap did not clear count and set flag");

  property p_ext_count;
    timer0_cfg_in.count_select && run0 && pin_fall[DMCT_PIN_CNT0] &&
    !sw_write_in.en && timer0_cfg_in.mode == DMCT_MODE_16BIT
    |=> {t0_high, t0_low} == $past({t0_high, t0_low}) + 16'h0001;
  endproperty
  a_ext_count: assert property (p_ext_count) // R3
    else $error("pin falling edge did not advance timer 0");

  property p_gate_closed;
    timer0_cfg_in.gate_enable && !sw_write_in.en &&
    pin_sync[DMCT_PIN_TIMER0_GATE_ENABLE] == timer0_cfg_in.gate_polarity
    |=> $stable(t0_low);
  endproperty
  a_gate_closed: assert property (p_gate_closed) // R6
    else $error("timer 0 counted with its gate closed");

  property p_mode2_reload;
    step0 && !sw_write_in.en && timer0_cfg_in.mode == DMCT_MODE_RELOAD8 &&
    t0_low == DMCT_BYTE_MAX
    |=> t0_low == $past(t0_high) && $stable(t0_high) ##1
        flags_out[DMCT_FLAG_T0];
  endproperty
  a_mode2_reload: assert property (p_mode2_reload) // R10
    else $error("mode 2 reload or flag wrong");

  property p_t1_no_flag;
    t0_split && ovf1 && !ovf0_high && !flags_out[DMCT_FLAG_T1]
    |=> !flags_out[DMCT_FLAG_T1];
  endproperty
  a_t1_no_flag: assert property (p_t1_no_flag) // R13
    else $error("timer 1 flagged while timer 0 split");

  property p_t1_stopped;
    t0_split && timer1_cfg_in.mode == DMCT_MODE_SPLIT8 && !sw_write_in.en
    |=> $stable({t1_high, t1_low});
  endproperty
  a_t1_stopped: assert property (p_t1_stopped) // R14
    else $error("timer 1 moved in mode 3 while timer 0 split");

  property p_uart_route;
    ovf1 |=> route_out.uart_baud ##1 (!route_out.uart_baud || $past(ovf1));
  endproperty
  a_uart_route: assert property (p_uart_route) // R15
    else $error("timer 1 overflow not routed to serial port");

  property p_irq_gate;
    !timer0_cfg_in.irq_enable |=> !irq_out[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R22
    else $error("interrupt raised with enable clear");

  property p_flag_sticky;
    flags_out[DMCT_FLAG_T0] && !flag_clear_in[DMCT_FLAG_T0]
    |=> flags_out[DMCT_FLAG_T0] [*1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R26
    else $error("timer 0 flag dropped without a clear");

  property p_adc_split;
    timer_n_cfg_in[0].split && w_lo_ovf[0] |=> route_out.adc_start[1];
  endproperty
  a_adc_split: assert property (p_adc_split) // R17
    else $error("split low overflow did not start converter");

  c_t0_ovf:    cover property (ovf0 ##2 irq_out[0] [*2]);
  c_t0_split:  cover property (t0_split && ovf0_high);
  c_wide_16:   cover property (!timer_n_cfg_in[0].split && w_hi_ovf[0]);
  c_ext_event: cover property (step0 && timer0_cfg_in.count_select);

endmodule

/* common/dmct_pkg.sv */
package dmct_pkg;

  // ---------------------------------------------------------------
  // operating modes and clock choices
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DMCT_MODE_13BIT   = 2'b00,
    DMCT_MODE_16BIT   = 2'b01,
    DMCT_MODE_RELOAD8 = 2'b10,
    DMCT_MODE_SPLIT8  = 2'b11
  } dmct_mode_t;

  // prescaled clock shared by the two classic timers
  typedef enum logic [1:0] {
    DMCT_DIV12 = 2'b00,
    DMCT_DIV4  = 2'b01,
    DMCT_DIV48 = 2'b10,
    DMCT_EXT8  = 2'b11
  } dmct_div_t;

  // alternate clock of the wide timers; code 11 falls back to div12
  typedef enum logic [1:0] {
    DMCT_ALT_DIV12 = 2'b00,
    DMCT_ALT_SRC_A = 2'b01,
    DMCT_ALT_SRC_B = 2'b10,
    DMCT_ALT_SPARE = 2'b11
  } dmct_alt_t;

  // software byte write targets
  typedef enum logic [3:0] {
    DMCT_SEL_T0L  = 4'h0,
    DMCT_SEL_T0H  = 4'h1,
    DMCT_SEL_T1L  = 4'h2,
    DMCT_SEL_T1H  = 4'h3,
    DMCT_SEL_T2L  = 4'h4,
    DMCT_SEL_T2H  = 4'h5,
    DMCT_SEL_T3L  = 4'h6,
    DMCT_SEL_T3H  = 4'h7,
    DMCT_SEL_T2RL = 4'h8,
    DMCT_SEL_T2RH = 4'h9,
    DMCT_SEL_T3RL = 4'hA,
    DMCT_SEL_T3RH = 4'hB
  } dmct_sel_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       run;
    logic       count_select;
    logic       gate_enable;
    logic       gate_polarity;
    logic       fast_clock_select;
    logic       irq_enable;
    dmct_mode_t mode;
  } dmct_classic_cfg_t;

  typedef struct packed {
    logic      run;
    logic      split;
    logic      low_clock_select;
    logic      high_clock_select;
    dmct_alt_t alt_clock_select;
    logic      irq_enable;
  } dmct_wide_cfg_t;

  typedef struct packed {
    logic       en;
    dmct_sel_t  sel;
    logic [7:0] data;
  } dmct_write_t;

  typedef struct packed {
    logic       uart_baud;
    logic [3:0] smbus_clk;
    logic       smbus_timeout;
    logic       pca_clk;
    logic [2:0] adc_start;
  } dmct_route_t;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  DMCT_BYTE_RST  = 8'h00;
  localparam logic [7:0]  DMCT_BYTE_MAX  = 8'hFF;
  localparam logic [12:0] DMCT_MAX13     = 13'h1FFF;
  localparam logic [15:0] DMCT_MAX16     = 16'hFFFF;
  localparam logic [3:0]  DMCT_DIV12_LAST = 4'hB;
  localparam logic [3:0]  DMCT_DIV12_RST  = 4'h0;
  localparam logic [1:0]  DMCT_DIV4_LAST  = 2'h3;
  localparam logic [1:0]  DMCT_DIV4_RST   = 2'h0;
  localparam int          DMCT_PIN_COUNT  = 8;
  // pin vector positions
  localparam int DMCT_PIN_CNT0 = 0;
  localparam int DMCT_PIN_CNT1 = 1;
  localparam int DMCT_PIN_TIMER0_GATE_ENABLE = 2;
  localparam int DMCT_PIN_GATE1 = 3;
  localparam int DMCT_PIN_EXT8 = 4;
  localparam int DMCT_PIN_RTC8 = 5;
  localparam int DMCT_PIN_CMP0 = 6;
  localparam int DMCT_PIN_CMP1 = 7;
  // flag vector positions
  localparam int DMCT_FLAG_T0  = 0;
  localparam int DMCT_FLAG_T1  = 1;
  localparam int DMCT_FLAG_W_H = 2;
  localparam int DMCT_FLAG_W_L = 4;

endpackage

/* tb/test_dual_mode_counter_timers.sv */
`timescale 1ns/1ps
module test_dual_mode_counter_timers
  import dmct_pkg::*;
;
  typedef struct {
    logic       t;
    dmct_mode_t m;
    logic       f;
    dmct_div_t  d;
    logic [7:0] h, l;
    int         n;
    logic [7:0] eh, el;
    logic       ef;
  } dmct_row_t;
  // ---------------------------------------------------------------
  // stimulus rows: timer, mode, fast, divider, load, steps, expect
  // ---------------------------------------------------------------
  dmct_row_t rows [9] = '{
    '{0, DMCT_MODE_13BIT, 1, DMCT_DIV12, 8'hFF, 8'h1F, 1, 8'h00, 8'h00, 1},
    '{0, DMCT_MODE_13BIT, 1, DMCT_DIV12, 8'h00, 8'h1E, 3, 8'h01, 8'h01, 0},
    '{1, DMCT_MODE_16BIT, 1, DMCT_DIV12, 8'hFF, 8'hFF, 1, 8'h00, 8'h00, 1},
    '{0, DMCT_MODE_16BIT, 1, DMCT_DIV12, 8'h12, 8'h34, 3, 8'h12, 8'h37, 0},
    '{1, DMCT_MODE_RELOAD8, 1, DMCT_DIV12, 8'h80, 8'hFF, 2, 8'h80, 8'h81, 1},
    '{0, DMCT_MODE_RELOAD8, 1, DMCT_DIV12, 8'hF0, 8'hFE, 3, 8'hF0, 8'hF1, 1},
    '{0, DMCT_MODE_16BIT, 0, DMCT_DIV4, 8'h00, 8'h10, 8, 8'h00, 8'h12, 0},
    '{1, DMCT_MODE_16BIT, 0, DMCT_DIV12, 8'h00, 8'h10, 24, 8'h00, 8'h12, 0},
    '{0, DMCT_MODE_16BIT, 0, DMCT_DIV48, 8'h00, 8'h10, 96, 8'h00, 8'h12, 0}
  };
  logic              clk, rst_n, p0, p1, g0, g1;
  dmct_classic_cfg_t c0, c1, cc;
  dmct_wide_cfg_t    wc [2];
  dmct_div_t         dv;
  dmct_write_t       wr;
  logic [5:0]        fc, fl;
  logic [7:0]        l0, h0, l1, h1;
  logic [1:0][7:0]   nl, nh;
  logic [3:0]        irq;
  dmct_route_t       rt, seen;
  dmct_row_t         r;
  int                failures, n_checks, cyc;

  dmct_timers dmct_timers_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
    .timer0_count_pin_in(p0), .timer1_count_pin_in(p1),
    .gate_input0_in(g0), .gate_input1_in(g1), .ext_osc_div8_in(1'b0),
    .rtc_osc_div8_in(1'b0), .cmp0_in(1'b0), .cmp1_in(1'b0),
    .timer0_cfg_in(c0), .timer1_cfg_in(c1), .timer_n_cfg_in(wc),
    .divider_choice_in(dv), .sw_write_in(wr), .flag_clear_in(fc),
    .timer0_low_byte_out(l0), .timer0_high_byte_out(h0),
    .timer1_low_byte_out(l1), .timer1_high_byte_out(h1),
    .timer_n_low_byte_out(nl), .timer_n_high_byte_out(nh),
    .flags_out(fl), .irq_out(irq), .route_out(rt));

  // free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // caller lowers the strobe, so back-to-back writes never glitch it
  task wb(input dmct_sel_t s, input logic [7:0] d);
    wr = '{1'b1, s, d};
    @(negedge clk);
  endtask
  task set_cfg(input logic t, input dmct_classic_cfg_t c);
    if (t) c1 = c;
    else c0 = c;
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence, inputs move on falling edges only
  initial begin
    {rst_n, p0, p1, g0, g1, fc} = '0;
    {c0, c1, dv, wr} = '0;
    wc = '{default: '0};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("reset low", 8'h00, l0);
    foreach (rows[i]) begin
      r = rows[i];
      cc = '{0, 0, 0, 0, r.f, 1, r.m};
      dv = r.d;
      set_cfg(r.t, cc);
      wb(dmct_sel_t'(2 * r.t + 1), r.h);
      wb(dmct_sel_t'(2 * r.t), r.l);
      wr.en = 1'b0;
      cc.run = 1'b1;
      set_cfg(r.t, cc);
      repeat (r.n) @(negedge clk);
      cc.run = 1'b0;
      set_cfg(r.t, cc);
      repeat (3) @(negedge clk);
      chk("high", r.eh, r.t ? h1 : h0);
      chk("low", r.el, (r.t ? l1 : l0) & (r.m == 0 ? 8'h1F : 8'hFF));
      chk("flag", {7'h00, r.ef}, {7'h00, fl[r.t]});
      chk("irq", {7'h00, r.ef}, {7'h00, irq[r.t]});
      fc[r.t] = 1'b1;
      @(negedge clk);
      fc = '0;
      $display("row %0d done", i);
    end
    // gate on timer 1: closed while low, open five cycles while high
    c1 = '{0, 0, 1, 0, 1, 1, DMCT_MODE_16BIT};
    wb(DMCT_SEL_T1L, 8'h00);
    wr.en = 1'b0;
    c1.run = 1'b1;
    repeat (6) @(negedge clk);
    g1 = 1'b1;
    repeat (5) @(negedge clk);
    g1 = 1'b0;
    repeat (4) @(negedge clk);
    c1.run = 1'b0;
    chk("gated", 8'h05, l1);
    $display("gate test done");
    // three falling edges on each count pin
    for (int t = 0; t < 2; t++) begin
      set_cfg(t, '{0, 1, 0, 0, 0, 1, DMCT_MODE_16BIT});
      wb(dmct_sel_t'(2 * t), 8'h00);
      wr.en = 1'b0;
      set_cfg(t, '{1, 1, 0, 0, 0, 1, DMCT_MODE_16BIT});
      repeat (3) begin
        {p1, p0} = t ? 2'h2 : 2'h1;
        repeat (4) @(negedge clk);
        {p1, p0} = 2'h0;
        repeat (4) @(negedge clk);
      end
      chk("pin count", 8'h03, t ? l1 : l0);
    end
    $display("pin test done");
    // split mode: high byte of timer 0 runs on timer 1 run bit
    fc = 6'h3F;
    @(negedge clk);
    fc = '0;
    // timer 0 low gated shut; timer 1 wraps without a flag
    c0 = '{1, 0, 1, 0, 1, 1, DMCT_MODE_SPLIT8};
    c1 = '{0, 0, 0, 0, 1, 0, DMCT_MODE_16BIT};
    wb(DMCT_SEL_T1H, 8'hFF);
    wb(DMCT_SEL_T1L, 8'hFF);
    wb(DMCT_SEL_T0H, 8'hFF);
    wr.en = 1'b0;
    c1.run = 1'b1;
    repeat (2) @(negedge clk);
    c1.run = 1'b0;
    repeat (3) @(negedge clk);
    chk("split high", 8'h01, h0);
    chk("t1 flag", 8'h01, {7'h00, fl[1]});
    chk("t0 flag", 8'h00, {7'h00, fl[0]});
    chk("t1 irq", 8'h00, {7'h00, irq[1]});
    c1.mode = DMCT_MODE_SPLIT8;
    wb(DMCT_SEL_T1L, 8'h55);
    wr.en = 1'b0;
    repeat (5) @(negedge clk);
    chk("t1 stopped", 8'h55, l1);
    $display("split test done");
    // wide timer 2: 16-bit wrap reloads, then split low wrap
    wc[0] = '{0, 0, 1, 0, DMCT_ALT_DIV12, 1};
    wb(DMCT_SEL_T2RL, 8'h34);
    wb(DMCT_SEL_T2RH, 8'h12);
    wb(DMCT_SEL_T2H, 8'hFF);
    wb(DMCT_SEL_T2L, 8'hFE);
    wr.en = 1'b0;
    wc[0].run = 1'b1;
    seen = '0;
    repeat (3) begin
      @(negedge clk);
      seen = seen | rt;
    end
    wc[0].run = 1'b0;
    @(negedge clk);
    chk("wide high", 8'h12, nh[0]);
    chk("wide low", 8'h35, nl[0]);
    chk("wide flags", 8'h14, {2'h0, fl[5:2], 2'h0});
    chk("wide irq", 8'h04, {4'h0, irq});
    chk("bus clk", 8'h0C, {4'h0, seen.smbus_clk});
    chk("adc 16", 8'h02, {5'h00, seen.adc_start});
    chk("route rest", 8'h00, {5'h00, seen[9], seen[4:3]});
    wc[0].split = 1'b1;
    wb(DMCT_SEL_T2L, 8'hFF);
    wr.en = 1'b0;
    seen = '0;
    repeat (2) begin
      @(negedge clk);
      seen = seen | rt;
    end
    wc[0] = '0;
    @(negedge clk);
    chk("split low", 8'h35, nl[0]);
    chk("adc split", 8'h02, {5'h00, seen.adc_start});
    $display("wide test done");
    end_sim();
  end
endmodule
